//--- rtl/cprx_pkg.sv
package cprx_pkg;

   // Clock and symbol timing.
   localparam int CLK_PERIOD_NS = 20;
   localparam int TX_SYMB_PERIOD_NS = 80;
   localparam int TX_SYMB_DIV_CYC = (TX_SYMB_PERIOD_NS + CLK_PERIOD_NS - 1)
                                    / CLK_PERIOD_NS;
   localparam logic [3:0] TX_SYMB_DIV_LAST = 4'(TX_SYMB_DIV_CYC - 1);

   // Quinary symbol coding: three-bit two's complement, -2 to +2.
   localparam int SYMB_W = 3;
   localparam int PAIRS = 4;
   localparam int SYMB_VEC_W = SYMB_W * PAIRS;
   localparam logic [SYMB_W-1:0] SYMB_ZERO = 3'h0;

   // Receive octet path.
   localparam int OCTET_W = 8;
   localparam int FIFO_DEPTH = 16;

   // Side-stream descrambler: 33-bit shift register, two taps per role.
   localparam int LFSR_W = 33;
   localparam int LFSR_TAP_MASTER = 12;
   localparam int LFSR_TAP_SLAVE = 19;
   localparam logic [LFSR_W-1:0] LFSR_SEED = 33'h0_0000_0001;

   // Consecutive idle symbols that end carrier.
   localparam logic [1:0] CS_IDLE_SYMS = 2'h2;

   // Role encoding on the role configuration report.
   localparam logic ROLE_SLAVE = 1'b0;
   localparam logic ROLE_MASTER = 1'b1;

   typedef enum logic [2:0] {
      CPRX_CS_RESET = 3'b001,
      CPRX_CS_IDLE = 3'b010,
      CPRX_CS_CARRIER = 3'b100
   } cprx_cs_t;

endpackage : cprx_pkg

//--- rtl/cprx_fifo.sv
`timescale 1ns/1ns
module cprx_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Filling side.
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Draining side.
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0] cnt;
   } cprx_fifo_st_t;

   cprx_fifo_st_t s_q, s_d;
   logic [WIDTH-1:0] mem [DEPTH];
   logic push, pop;

   assign in_ready = s_q.cnt != (AW+1)'(DEPTH);
   assign out_valid = s_q.cnt != '0;
   assign out_data = mem[s_q.rd];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      s_d = s_q;
      if (push) begin
         s_d.wr = s_q.wr + 1'b1;
      end
      if (pop) begin
         s_d.rd = s_q.rd + 1'b1;
      end
      case ({push, pop})
         2'b10: s_d.cnt = s_q.cnt + 1'b1;
         2'b01: s_d.cnt = s_q.cnt - 1'b1;
         default: s_d.cnt = s_q.cnt;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   always_ff @(posedge clk) begin
      if (push) begin
         mem[s_q.wr] <= in_data;
      end
   end

endmodule : cprx_fifo

//--- rtl/cprx_core.sv
`timescale 1ns/1ns
// Behaviour
// RULE1: Descramble received data and deliver octets in order on rxd.
// RULE2: As master, descrambler uses the master generator polynomial.
// RULE3: As slave, descrambler uses the distinct slave generator polynomial.
// RULE4: Coding sublayer resets on power-on or management request.
// RULE5: Carrier sense tracks line activity and reports carrier.
// RULE6: Symbol tick is generated synchronously with the transmit clock.
// RULE7: Attachment resets on power-on, management or PHY control request.
// RULE8: Transmit continuously drives one quinary symbol per pair A to D.
// RULE9: All four pair transmitters share one transmit symbol clock.
// RULE10: Master role sources the transmit clock locally.
// RULE11: Slave role derives the transmit clock from the recovered clock.
// RULE12: Receive turns four pair signals into a reported symbol group.
// RULE13: Attachment continuously reports the role configuration.
// RULE14: Descrambler resets with coding; polynomial switches only when idle.
// RULE15: Receive octets and carrier follow a clock from recovered symbols.
module cprx_core
   import cprx_pkg::*;
(
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Reset requests and role, from pins.
   input wire logic mgmt_reset_req,
   input wire logic phy_ctl_reset_req,
   input wire logic role_master_in,
   // Received pairs and recovered symbol clock, from pins.
   input wire logic recovered_symbol_clock,
   input wire logic [SYMB_W-1:0] rx_pair_a,
   input wire logic [SYMB_W-1:0] rx_pair_b,
   input wire logic [SYMB_W-1:0] rx_pair_c,
   input wire logic [SYMB_W-1:0] rx_pair_d,
   // Transmit symbol group from the encoder.
   input wire logic [SYMB_W-1:0] tx_symb_a,
   input wire logic [SYMB_W-1:0] tx_symb_b,
   input wire logic [SYMB_W-1:0] tx_symb_c,
   input wire logic [SYMB_W-1:0] tx_symb_d,
   // Line drive.
   output logic [SYMB_W-1:0] line_pair_a,
   output logic [SYMB_W-1:0] line_pair_b,
   output logic [SYMB_W-1:0] line_pair_c,
   output logic [SYMB_W-1:0] line_pair_d,
   output logic transmit_symbol_clock,
   output logic symbol_tick,
   // Reports to the coding sublayer.
   output logic role_config_report,
   output logic received_symbol_valid,
   output logic [SYMB_VEC_W-1:0] received_symbol_report,
   output logic coding_reset_active,
   output logic attachment_reset_active,
   // GMII receive side.
   output logic gmii_rx_clk,
   output logic [OCTET_W-1:0] gmii_rxd,
   output logic gmii_rx_dv,
   output logic gmii_crs,
   input wire logic rx_out_ready,
   output logic rx_overrun
);

   typedef struct packed {
      logic [1:0] mgmt_s;
      logic [1:0] ctl_s;
      logic [1:0] role_s;
      logic [1:0] rclk_s;
      logic rclk_prev;
      logic [SYMB_VEC_W-1:0] sym_s0;
      logic [SYMB_VEC_W-1:0] sym_s1;
      logic role_rep;
      logic role_sel;
      logic [3:0] div;
      logic txclk;
      logic [SYMB_VEC_W-1:0] pairs;
      logic [LFSR_W-1:0] lfsr;
      logic pend;
      logic [OCTET_W-1:0] pend_data;
      cprx_cs_t cs;
      logic [1:0] idle_cnt;
      logic rxclk;
      logic rep_valid;
      logic [SYMB_VEC_W-1:0] rep;
      logic [OCTET_W-1:0] rxd;
      logic rxdv;
      logic overrun;
   } cprx_st_t;

   cprx_st_t s_q, s_d;

   logic coding_rst, attach_rst, rx_edge, tick, line_idle;
   logic fifo_in_ready, fifo_out_valid, fifo_pop;
   logic [OCTET_W-1:0] fifo_out_data, rx_octet;
   logic [LFSR_W-1:0] lfsr_next;
   logic [OCTET_W-1:0] scr_byte;

   // Advances the descrambler eight steps; the tap follows the role.
   function automatic logic [LFSR_W+OCTET_W-1:0] lfsr_step8(
      input logic [LFSR_W-1:0] st, input logic master);
      logic [LFSR_W-1:0] v;
      logic [OCTET_W-1:0] o;
      logic fb;
      v = st;
      o = '0;
      for (int i = 0; i < OCTET_W; i++) begin
         fb = v[LFSR_W-1] ^ (master ? v[LFSR_TAP_MASTER] : v[LFSR_TAP_SLAVE]);
         o[i] = fb;
         v = {v[LFSR_W-2:0], fb};
      end
      return {v, o};
   endfunction : lfsr_step8

   // Maps one nonzero quinary symbol onto two data bits.
   function automatic logic [1:0] symb_bits(input logic [SYMB_W-1:0] v);
      logic mag2;
      mag2 = (v == 3'h2) || (v == 3'h6);
      return {v[SYMB_W-1], mag2};
   endfunction : symb_bits

   assign coding_rst = s_q.mgmt_s[1];
   assign attach_rst = s_q.mgmt_s[1] || s_q.ctl_s[1];
   assign rx_edge = s_q.rclk_s[1] && !s_q.rclk_prev;
   assign line_idle = s_q.sym_s1 == '0;
   assign {lfsr_next, scr_byte} = lfsr_step8(s_q.lfsr, s_q.role_sel);
   assign rx_octet = {symb_bits(s_q.sym_s1[11:9]), symb_bits(s_q.sym_s1[8:6]),
                      symb_bits(s_q.sym_s1[5:3]), symb_bits(s_q.sym_s1[2:0])}
                     ^ scr_byte;
   assign fifo_pop = fifo_out_valid && rx_out_ready;

   // RULE6 tick from clock source
   // RULE10 local divider as master
   // RULE11 recovered edge as slave
   assign tick = !attach_rst && ((s_q.role_rep == ROLE_MASTER)
                              ? (s_q.div == '0) : rx_edge);

   always_comb begin
      s_d = s_q;
      s_d.mgmt_s = {s_q.mgmt_s[0], mgmt_reset_req};
      s_d.ctl_s = {s_q.ctl_s[0], phy_ctl_reset_req};
      s_d.role_s = {s_q.role_s[0], role_master_in};
      s_d.rclk_s = {s_q.rclk_s[0], recovered_symbol_clock};
      s_d.rclk_prev = s_q.rclk_s[1];
      s_d.sym_s0 = {rx_pair_a, rx_pair_b, rx_pair_c, rx_pair_d};
      s_d.sym_s1 = s_q.sym_s0;
      // RULE13 continuous role report
      s_d.role_rep = s_q.role_s[1];
      s_d.rep_valid = 1'b0;
      s_d.rxdv = 1'b0;

      // RULE7 attachment reset
      if (attach_rst) begin
         s_d.div = TX_SYMB_DIV_LAST;
         s_d.txclk = 1'b0;
         s_d.pairs = '0;
      end else begin
         s_d.div = (s_q.div == '0) ? TX_SYMB_DIV_LAST : s_q.div - 1'b1;
         // RULE8 continuous per pair drive
         // RULE9 one common tick
         if (tick) begin
            s_d.txclk = !s_q.txclk;
            s_d.pairs = {tx_symb_a, tx_symb_b, tx_symb_c, tx_symb_d};
         end
         // RULE12 received symbol group
         if (rx_edge) begin
            s_d.rep_valid = 1'b1;
            s_d.rep = s_q.sym_s1;
         end
      end

      // RULE4 coding reset
      // RULE14 descrambler reset with coding
      if (coding_rst) begin
         s_d.cs = CPRX_CS_RESET;
         s_d.lfsr = LFSR_SEED;
         s_d.pend = 1'b0;
         s_d.idle_cnt = '0;
         s_d.overrun = 1'b0;
         s_d.role_sel = s_q.role_rep;
      end else begin
         // RULE14 switch only when not carrying
         if (s_q.cs != CPRX_CS_CARRIER) begin
            s_d.role_sel = s_q.role_rep;
         end
         if (s_q.pend && fifo_in_ready) begin
            s_d.pend = 1'b0;
         end
         if (rx_edge) begin
            // RULE15 receive clock from recovered symbols
            s_d.rxclk = !s_q.rxclk;
            // RULE2 master polynomial
            // RULE3 slave polynomial
            s_d.lfsr = lfsr_next;
            // RULE5 carrier sense process
            case (s_q.cs)
               CPRX_CS_RESET: s_d.cs = CPRX_CS_IDLE;
               CPRX_CS_IDLE: begin
                  s_d.idle_cnt = '0;
                  if (!line_idle) begin
                     s_d.cs = CPRX_CS_CARRIER;
                  end
               end
               CPRX_CS_CARRIER: begin
                  if (!line_idle) begin
                     s_d.idle_cnt = '0;
                  end else if (s_q.idle_cnt == CS_IDLE_SYMS - 1'b1) begin
                     s_d.cs = CPRX_CS_IDLE;
                     s_d.idle_cnt = '0;
                  end else begin
                     s_d.idle_cnt = s_q.idle_cnt + 1'b1;
                  end
               end
               default: s_d.cs = CPRX_CS_RESET;
            endcase
            // RULE1 descrambled octet queued in order
            if (s_q.cs == CPRX_CS_CARRIER && !line_idle) begin
               if (s_q.pend && !fifo_in_ready) begin
                  s_d.overrun = 1'b1;
               end else begin
                  s_d.pend = 1'b1;
                  s_d.pend_data = rx_octet;
               end
            end
         end
      end

      // RULE1 octet to GMII
      if (fifo_pop) begin
         s_d.rxd = fifo_out_data;
         s_d.rxdv = 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s_q <= '0;
         s_q.cs <= CPRX_CS_RESET;
         s_q.lfsr <= LFSR_SEED;
         s_q.div <= TX_SYMB_DIV_LAST;
      end else begin
         s_q <= s_d;
      end
   end

   // The octet queue absorbs bursts while the GMII consumer stalls.
   cprx_fifo #(
      .WIDTH(OCTET_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .rst(rst || coding_rst),
      .in_valid(s_q.pend),
      .in_ready(fifo_in_ready),
      .in_data(s_q.pend_data),
      .out_valid(fifo_out_valid),
      .out_ready(rx_out_ready),
      .out_data(fifo_out_data)
   );

   assign {line_pair_a, line_pair_b, line_pair_c, line_pair_d} = s_q.pairs;
   assign transmit_symbol_clock = s_q.txclk;
   assign symbol_tick = tick;
   assign role_config_report = s_q.role_rep;
   assign received_symbol_valid = s_q.rep_valid;
   assign received_symbol_report = s_q.rep;
   assign coding_reset_active = coding_rst;
   assign attachment_reset_active = attach_rst;
   assign gmii_rx_clk = s_q.rxclk;
   assign gmii_rxd = s_q.rxd;
   assign gmii_rx_dv = s_q.rxdv;
   assign gmii_crs = s_q.cs == CPRX_CS_CARRIER;
   assign rx_overrun = s_q.overrun;

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   rxd_in_order_a: assert property (fifo_pop |=> gmii_rx_dv && // RULE1
      gmii_rxd == $past(fifo_out_data)) else $error("rxd mismatch");
   master_poly_a: assert property (!coding_rst && rx_edge && // RULE2
      s_q.role_sel == ROLE_MASTER |=> s_q.lfsr[0] ==
      ($past(s_q.lfsr[25]) ^ $past(s_q.lfsr[5]))) else $error("master tap");
   slave_poly_a: assert property (!coding_rst && rx_edge && // RULE3
      s_q.role_sel == ROLE_SLAVE |=> s_q.lfsr[0] ==
      ($past(s_q.lfsr[25]) ^ $past(s_q.lfsr[12]))) else $error("slave tap");
   coding_reset_a: assert property (coding_rst |=> // RULE4
      s_q.cs == CPRX_CS_RESET && !gmii_crs && s_q.lfsr == LFSR_SEED)
      else $error("coding reset");
   carrier_rise_a: assert property (!coding_rst && rx_edge && // RULE5
      s_q.cs == CPRX_CS_IDLE && !line_idle |=> gmii_crs)
      else $error("carrier missed");
   master_tick_a: assert property (tick && // RULE10
      s_q.role_rep == ROLE_MASTER |=>
      (!tick || s_q.role_rep != ROLE_MASTER) [*3] ##1
      (tick || attach_rst || s_q.role_rep != ROLE_MASTER))
      else $error("master tick");
   pair_drive_a: assert property (tick |=> line_pair_a == // RULE9
      $past(tx_symb_a) && line_pair_d == $past(tx_symb_d))
      else $error("pair drive");
   ctl_reset_a: assert property ($rose(s_q.ctl_s[1]) |-> // RULE7
      attachment_reset_active ##1 line_pair_a == SYMB_ZERO)
      else $error("attachment reset");
   symb_report_a: assert property (!attach_rst && rx_edge |=> // RULE12
      received_symbol_valid && received_symbol_report == $past(s_q.sym_s1))
      else $error("symbol report");
   role_hold_a: assert property (s_q.cs == CPRX_CS_CARRIER && // RULE14
      !coding_rst |=> $stable(s_q.role_sel)) else $error("role switched");

endmodule : cprx_core

//--- testbench/cprx_link_partner.sv
`timescale 1ns/1ns
module cprx_link_partner
   import cprx_pkg::*;
(
   // Clock.
   input wire logic clk,
   // Line toward the device.
   output logic rclk,
   output logic [SYMB_W-1:0] pa,
   output logic [SYMB_W-1:0] pb,
   output logic [SYMB_W-1:0] pc,
   output logic [SYMB_W-1:0] pd
);
   initial begin
      rclk = 1'b0;
      {pa, pb, pc, pd} = 12'h000;
   end

   // The clock stands still between groups; stale data is inverted.
   task automatic send(input logic [SYMB_VEC_W-1:0] grp);
      @(negedge clk);
      {pa, pb, pc, pd} = grp;
      repeat (3) @(negedge clk);
      rclk = 1'b1;
      repeat (5) @(negedge clk);
      rclk = 1'b0;
      {pa, pb, pc, pd} = ~grp;
   endtask : send
endmodule : cprx_link_partner

//--- testbench/test_copper_phy_rx_descramble_pma_ctl.sv
`timescale 1ns/1ns
module test_copper_phy_rx_descramble_pma_ctl
   import cprx_pkg::*;
;
   logic clk, rst, mgmt_reset_req, phy_ctl_reset_req, role_master_in;
   logic recovered_symbol_clock, rx_out_ready, transmit_symbol_clock;
   logic [SYMB_W-1:0] rx_pair_a, rx_pair_b, rx_pair_c, rx_pair_d;
   logic [SYMB_W-1:0] tx_symb_a, tx_symb_b, tx_symb_c, tx_symb_d;
   logic [SYMB_W-1:0] line_pair_a, line_pair_b, line_pair_c, line_pair_d;
   logic symbol_tick, role_config_report, received_symbol_valid;
   logic [SYMB_VEC_W-1:0] received_symbol_report, last;
   logic coding_reset_active, attachment_reset_active;
   logic [OCTET_W-1:0] gmii_rxd;
   logic gmii_rx_dv, gmii_crs, rx_overrun, role_model;
   logic gmii_rx_clk, rxclk_seen;
   logic [LFSR_W-1:0] lf;
   logic [SYMB_W-1:0] lg[5] = '{3'h0, 3'h1, 3'h2, 3'h6, 3'h7};
   logic [7:0] got[$], exp_q[$];
   int n_mismatch = 0, total_checks = 0, ticks = 0, rxclk_n = 0, nval = 0;

   cprx_core uut (
      .clk, .rst, .mgmt_reset_req, .phy_ctl_reset_req, .role_master_in,
      .recovered_symbol_clock, .rx_pair_a, .rx_pair_b, .rx_pair_c,
      .rx_pair_d, .tx_symb_a, .tx_symb_b, .tx_symb_c, .tx_symb_d,
      .line_pair_a, .line_pair_b, .line_pair_c, .line_pair_d,
      .transmit_symbol_clock, .symbol_tick, .role_config_report,
      .received_symbol_valid, .received_symbol_report,
      .coding_reset_active, .attachment_reset_active, .gmii_rx_clk,
      .gmii_rxd, .gmii_rx_dv, .gmii_crs, .rx_out_ready, .rx_overrun
   );

   cprx_link_partner lp (
      .clk, .rclk(recovered_symbol_clock), .pa(rx_pair_a),
      .pb(rx_pair_b), .pc(rx_pair_c), .pd(rx_pair_d)
   );

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value at %0t: %0h expected %0h", $time, seen, exp);
      end
   endtask : check

   task automatic wrap_up();
      if (n_mismatch == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : wrap_up

   always @(negedge clk) begin
      if (symbol_tick === 1'b1) ticks++;
      if (gmii_rx_dv === 1'b1) got.push_back(gmii_rxd);
      if (gmii_rx_clk !== rxclk_seen) rxclk_n++;
      rxclk_seen = gmii_rx_clk;
      if (received_symbol_valid === 1'b1) begin
         nval++;
         check(received_symbol_report, last);
      end
   end

   function automatic logic [7:0] oct(input logic [11:0] g);
      return {g[11], g[10:9] == 2'h2, g[8], g[7:6] == 2'h2,
              g[5], g[4:3] == 2'h2, g[2], g[1:0] == 2'h2};
   endfunction : oct

   // Steps the reference descrambler eight times, then sends the group.
   task automatic sym(input logic [11:0] g, output logic [7:0] b);
      last = g;
      for (int i = 0; i < 8; i++) begin
         b[i] = lf[32] ^ lf[role_model ? LFSR_TAP_MASTER : LFSR_TAP_SLAVE];
         lf = {lf[31:0], b[i]};
      end
      lp.send(g);
   endtask : sym

   task automatic tx_master();
      int gap;
      logic t0;
      check(role_config_report, 1'b1);
      for (int i = 0; i < 3; i++) begin
         {tx_symb_a, tx_symb_b, tx_symb_c, tx_symb_d} = {lg[i], 9'h0B7};
         gap = 0;
         do begin
            @(negedge clk);
            gap++;
         end while (symbol_tick !== 1'b1 && gap < 20);
         t0 = transmit_symbol_clock;
         @(negedge clk);
         check({line_pair_a, line_pair_b, line_pair_c, line_pair_d},
               {lg[i], 9'h0B7});
         check(transmit_symbol_clock, !t0);
         if (i > 0) check(gap, 3);
      end
   endtask : tx_master

   task automatic reset_run();
      int t0;
      phy_ctl_reset_req = 1'b1;
      repeat (3) @(negedge clk);
      #1;
      t0 = ticks;
      check(attachment_reset_active, 1'b1);
      check(coding_reset_active, 1'b0);
      repeat (8) @(negedge clk);
      check({line_pair_a, line_pair_b, line_pair_c, line_pair_d}, 0);
      check(ticks - t0, 0);
      phy_ctl_reset_req = 1'b0;
      mgmt_reset_req = 1'b1;
      repeat (3) @(negedge clk);
      check(coding_reset_active, 1'b1);
      check(attachment_reset_active, 1'b1);
      mgmt_reset_req = 1'b0;
      repeat (4) @(negedge clk);
      check(coding_reset_active, 1'b0);
   endtask : reset_run

   task automatic rx_run(input logic m, input int n, input logic rdy);
      logic [7:0] b;
      logic [11:0] g;
      int t0, r0, v0;
      role_model = m;
      role_master_in = m;
      rx_out_ready = rdy;
      mgmt_reset_req = 1'b1;
      repeat (4) @(negedge clk);
      mgmt_reset_req = 1'b0;
      repeat (4) @(negedge clk);
      lf = LFSR_SEED;
      got.delete();
      exp_q.delete();
      t0 = ticks;
      r0 = rxclk_n;
      v0 = nval;
      check(rx_overrun, 1'b0);
      check(role_config_report, m);
      // The first group after reset only takes carrier sense out of reset.
      sym(12'h000, b);
      check(gmii_crs, 1'b0);
      sym(12'h001, b);
      check(gmii_crs, 1'b1);
      for (int k = 0; k < n; k++) begin
         g = {lg[k % 5], lg[(k + 1) % 5], lg[(k + 2) % 5], lg[(k + 3) % 5]};
         if (k == 2 && m) role_master_in = 1'b0;
         sym(g, b);
         exp_q.push_back(oct(g) ^ b);
      end
      role_master_in = m;
      sym(12'h000, b);
      sym(12'h000, b);
      check(gmii_crs, 1'b0);
      check(rx_overrun, n > FIFO_DEPTH);
      rx_out_ready = 1'b1;
      repeat (60) @(negedge clk);
      // A full queue keeps one pending octet; later ones are dropped.
      check(got.size(), n > FIFO_DEPTH ? FIFO_DEPTH + 1 : n);
      for (int i = 0; i < got.size(); i++)
         check(got[i], exp_q[i]);
      if (!m) check(ticks - t0, n + 4);
      check(rxclk_n - r0, n + 4);
      check(nval - v0, n + 4);
   endtask : rx_run

   initial begin
      rst = 1'b1;
      mgmt_reset_req = 1'b0;
      phy_ctl_reset_req = 1'b0;
      role_master_in = ROLE_MASTER;
      rx_out_ready = 1'b1;
      {tx_symb_a, tx_symb_b, tx_symb_c, tx_symb_d} = 12'h000;
      repeat (16) @(negedge clk);
      rst = 1'b0;
      repeat (16) @(negedge clk);
      tx_master();
      reset_run();
      rx_run(ROLE_MASTER, 6, 1'b1);
      rx_run(ROLE_SLAVE, 6, 1'b1);
      rx_run(ROLE_MASTER, 20, 1'b0);
      wrap_up();
   end

   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      wrap_up();
   end
endmodule : test_copper_phy_rx_descramble_pma_ctl
